// File: rcp_parser.sv
// Receiver configuration packet parser, reply builder and register slave
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rcp_parser
  import rcp_pkg::*;
#(
  parameter logic [31:0] RST_MASK = BAND_SUPPORTED,
  parameter logic [31:0] RST_ELEV = 32'h0000_0000
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic      [31:0] band_enable_out,
  output logic      [31:0] elev_min_out,
  output logic             elev_apply_out,
  output logic             frame_ok_out,
  output logic             frame_err_out,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_BODY = 4'b0010,
    RX_DLE1 = 4'b0100,
    RX_DLE2 = 4'b1000
  } rcp_rx_state_type;

  rcp_rx_state_type rx_state_q;
  logic [15:0]      pos_q;
  logic [15:0]      len_q;
  logic [7:0]       mode_q;
  logic [31:0]      mask_buf_q;
  logic [31:0]      elev_buf_q;
  rcp_cfg_type      cfg_q;
  rcp_cfg_type      tx_cfg_q;
  logic [2:0]       ctrl_q;
  logic [7:0]       ok_cnt_q;
  logic [7:0]       err_cnt_q;
  logic             reply_pend_q;
  logic             tx_act_q;
  logic [4:0]       tx_pos_q;
  logic             ack_q;

  logic             rx_take;
  logic             frame_end;
  logic             frame_done;
  logic             frame_bad;
  logic             mode_ok;
  logic             mask_take;
  logic             elev_take;
  logic             tx_start;
  logic             tx_step;
  logic             bus_wr;
  logic [16:0]      end_pos;
  logic [31:0]      ctrl_merge;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
    return r;
  endfunction : be_merge

  function automatic logic [7:0] reply_byte(input logic [4:0]  p,
                                            input rcp_cfg_type c);
    logic [7:0] b;
    unique case (p)
      5'h00:   b = START_BYTE;
      5'h01:   b = PACKET_ID;
      5'h02:   b = MSG_SUBCODE;
      5'h03:   b = REPLY_LEN[15:8];
      5'h04:   b = REPLY_LEN[7:0];
      5'h05:   b = MODE_RESP;
      5'h06:   b = c.mask[31:24];
      5'h07:   b = c.mask[23:16];
      5'h08:   b = c.mask[15:8];
      5'h09:   b = c.mask[7:0];
      5'h0A:   b = c.elev[31:24];
      5'h0B:   b = c.elev[23:16];
      5'h0C:   b = c.elev[15:8];
      5'h0D:   b = c.elev[7:0];
      5'h0E:   b = PACKET_ID ^ MSG_SUBCODE ^ REPLY_LEN[15:8] ^ REPLY_LEN[7:0] ^ MODE_RESP
                   ^ c.mask[31:24] ^ c.mask[23:16] ^ c.mask[15:8] ^ c.mask[7:0]
                   ^ c.elev[31:24] ^ c.elev[23:16] ^ c.elev[15:8] ^ c.elev[7:0];
      5'h0F:   b = END_BYTE_1;
      5'h10:   b = END_BYTE_2;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : reply_byte

  assign rx_take    = rx_valid_in && ctrl_q[CTRL_PARSE_EN];
  assign end_pos    = {1'b0, len_q} + LEN_POS_BIAS;
  assign frame_end  = (pos_q >= POS_MODE) && ({1'b0, pos_q} == end_pos);
  assign mode_ok    = (mode_q == MODE_QUERY) || (mode_q == MODE_SET);
  assign frame_done = rx_take && (rx_state_q == RX_DLE2)
                      && (rx_data_in == END_BYTE_2) && mode_ok;
  assign frame_bad  = rx_take && (((rx_state_q == RX_DLE1) && (rx_data_in != END_BYTE_1))
                      || ((rx_state_q == RX_DLE2) && ((rx_data_in != END_BYTE_2) || !mode_ok))
                      || ((rx_state_q == RX_BODY) && (pos_q == POS_LEN_LO)
                          && ({len_q[15:8], rx_data_in} == 16'h0000)));
  // All-FF keeps a field; unsigned compare also refuses negative floats
  assign mask_take  = frame_done && (mode_q == MODE_SET) && (len_q >= LEN_WITH_MASK)
                      && (mask_buf_q != {4{FIELD_SKIP}});
  assign elev_take  = frame_done && (mode_q == MODE_SET) && (len_q >= LEN_WITH_ELEV)
                      && (elev_buf_q != {4{FIELD_SKIP}})
                      && (elev_buf_q <= ELEV_MAX_90DEG);
  assign tx_start   = reply_pend_q && !tx_act_q;
  assign tx_step    = tx_valid_out && tx_ready_in;
  assign bus_wr     = avs_write_in && ack_q;
  assign ctrl_merge = be_merge({29'h0000_0000, ctrl_q}, avs_writedata_in, avs_byteenable_in);

  // Frame recogniser
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state_q <= RX_IDLE;
      pos_q      <= 16'h0000;
      len_q      <= 16'h0000;
    end else if (rx_take) begin
      pos_q <= pos_q + 16'h0001;
      unique case (rx_state_q)
        RX_IDLE: begin
          pos_q <= POS_PKT_ID;
          if (rx_data_in == START_BYTE) begin
            rx_state_q <= RX_BODY;
          end
        end
        RX_BODY: begin
          if ((pos_q == POS_PKT_ID && rx_data_in != PACKET_ID)
              || (pos_q == POS_SUBCODE && rx_data_in != MSG_SUBCODE)) begin
            rx_state_q <= RX_IDLE;
          end else if (pos_q == POS_LEN_HI) begin
            len_q[15:8] <= rx_data_in;
          end else if (pos_q == POS_LEN_LO) begin
            len_q[7:0] <= rx_data_in;
            if ({len_q[15:8], rx_data_in} == 16'h0000) begin
              rx_state_q <= RX_IDLE;
            end
          end else if (frame_end) begin
            rx_state_q <= RX_DLE1;
          end
        end
        RX_DLE1: begin
          rx_state_q <= (rx_data_in == END_BYTE_1) ? RX_DLE2 : RX_IDLE;
        end
        RX_DLE2: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Field capture, big-endian
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q     <= 8'h00;
      mask_buf_q <= 32'h0000_0000;
      elev_buf_q <= 32'h0000_0000;
    end else if (rx_take && rx_state_q == RX_BODY && !frame_end) begin
      if (pos_q == POS_MODE) begin
        mode_q <= rx_data_in;
      end
      if (pos_q >= POS_MASK_LO && pos_q <= POS_MASK_HI) begin
        mask_buf_q <= {mask_buf_q[23:0], rx_data_in};
      end
      if (pos_q >= POS_ELEV_LO && pos_q <= POS_ELEV_HI) begin
        elev_buf_q <= {elev_buf_q[23:0], rx_data_in};
      end
    end
  end

  // Stored configuration; a frame commit overrides a same-cycle bus write
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q  <= '{mask: RST_MASK, elev: RST_ELEV};
      ctrl_q <= CTRL_RESET;
    end else begin
      if (bus_wr && avs_address_in == REG_CTRL) begin
        ctrl_q <= ctrl_merge[2:0];
      end
      if (bus_wr && avs_address_in == REG_MASK) begin
        cfg_q.mask <= be_merge(cfg_q.mask, avs_writedata_in, avs_byteenable_in);
      end
      if (bus_wr && avs_address_in == REG_ELEV
          && be_merge(cfg_q.elev, avs_writedata_in, avs_byteenable_in) <= ELEV_MAX_90DEG) begin
        cfg_q.elev <= be_merge(cfg_q.elev, avs_writedata_in, avs_byteenable_in);
      end
      if (mask_take) begin
        cfg_q.mask <= mask_buf_q;
      end
      if (elev_take) begin
        cfg_q.elev <= elev_buf_q;
      end
    end
  end

  // Outputs towards the tracking logic
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      band_enable_out <= 32'h0000_0000;
      elev_min_out    <= 32'h0000_0000;
      elev_apply_out  <= 1'b0;
      frame_ok_out    <= 1'b0;
      frame_err_out   <= 1'b0;
      ok_cnt_q        <= 8'h00;
      err_cnt_q       <= 8'h00;
    end else begin
      band_enable_out <= cfg_q.mask & BAND_SUPPORTED;
      elev_min_out    <= cfg_q.elev;
      elev_apply_out  <= ctrl_q[CTRL_OD_MODE];
      frame_ok_out    <= frame_done;
      frame_err_out   <= frame_bad;
      ok_cnt_q        <= ok_cnt_q + {7'h00, frame_done};
      err_cnt_q       <= err_cnt_q + {7'h00, frame_bad};
    end
  end

  // Reply request; a new frame wins over the clear
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reply_pend_q <= 1'b0;
    end else if (frame_done && ctrl_q[CTRL_REPLY_EN]) begin
      reply_pend_q <= 1'b1;
    end else if (tx_start) begin
      reply_pend_q <= 1'b0;
    end
  end

  // Reply byte stream
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_act_q     <= 1'b0;
      tx_pos_q     <= 5'h00;
      tx_cfg_q     <= '0;
      tx_data_out  <= 8'h00;
      tx_valid_out <= 1'b0;
    end else if (tx_start) begin
      tx_act_q     <= 1'b1;
      tx_pos_q     <= 5'h00;
      tx_cfg_q     <= cfg_q;
      tx_data_out  <= START_BYTE;
      tx_valid_out <= 1'b1;
    end else if (tx_step) begin
      if (tx_pos_q == TX_POS_LAST) begin
        tx_act_q     <= 1'b0;
        tx_valid_out <= 1'b0;
      end else begin
        tx_pos_q    <= tx_pos_q + 5'h01;
        tx_data_out <= reply_byte(tx_pos_q + 5'h01, tx_cfg_q);
      end
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request appears
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      ack_q               <= (avs_read_in || avs_write_in) && !ack_q;
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
      if (avs_read_in && !ack_q) begin
        unique case (avs_address_in)
          REG_CTRL:   avs_readdata_out <= {29'h0000_0000, ctrl_q};
          REG_STATUS: avs_readdata_out <= {14'h0000, tx_act_q, rx_state_q != RX_IDLE,
                                           err_cnt_q, ok_cnt_q};
          REG_MASK:   avs_readdata_out <= cfg_q.mask;
          REG_BAND:   avs_readdata_out <= band_enable_out;
          REG_ELEV:   avs_readdata_out <= cfg_q.elev;
          default:    avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_bus_answer: assert property ((avs_read_in || avs_write_in) && !ack_q
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle after request");
  a_reply_start: assert property (tx_start |=> tx_valid_out && tx_data_out == START_BYTE
    && tx_pos_q == 5'h00) else $error("reply does not open with start byte");
  a_reply_ident: assert property (tx_valid_out && tx_pos_q == 5'h00 && tx_ready_in
    |=> tx_data_out == PACKET_ID ##0 tx_valid_out) else $error("reply packet id wrong");
  a_reply_length: assert property (tx_valid_out && tx_pos_q == 5'h04
    |-> tx_data_out == REPLY_LEN[7:0]) else $error("reply length byte wrong");
  a_reply_mode: assert property (tx_valid_out && tx_pos_q == 5'h05
    |-> tx_data_out == MODE_RESP) else $error("reply mode not response");
  a_mask_capture: assert property (mask_take |=> cfg_q.mask == $past(mask_buf_q))
    else $error("mask not taken from frame");
  a_band_l5: assert property (1'b1 |=> band_enable_out[2] == $past(cfg_q.mask[2]))
    else $error("band bit 2 not following mask");
  a_band_e5a: assert property (1'b1 |=> band_enable_out[17] == $past(cfg_q.mask[17]))
    else $error("band bit 17 not following mask");
  a_band_reserved: assert property (##1 (band_enable_out & ~BAND_SUPPORTED) == 32'h0)
    else $error("reserved band bit acted on");
  a_elev_range: assert property (elev_take |=> (cfg_q.elev <= ELEV_MAX_90DEG)
    ##1 elev_min_out == $past(cfg_q.elev)) else $error("elevation out of range");
  a_skip_keep: assert property (frame_done && mode_q == MODE_SET
    && mask_buf_q == {4{FIELD_SKIP}} && !bus_wr |=> $stable(cfg_q.mask))
    else $error("all-FF mask changed setting");
  a_trailer_reject: assert property (rx_take && rx_state_q == RX_DLE1
    && rx_data_in != END_BYTE_1 |=> frame_err_out && !frame_ok_out ##1 !frame_ok_out)
    else $error("bad trailer accepted");
  c_frame_ok:    cover property (frame_ok_out);
  c_frame_err:   cover property (frame_err_out);
  c_reply_done:  cover property (tx_step && tx_pos_q == TX_POS_LAST);
  c_skip_field:  cover property (frame_done && !mask_take && mode_q == MODE_SET);

endmodule : rcp_parser

`default_nettype wire

// File: rcp_pkg.sv
// Shared constants and types for the receiver configuration packet parser
package rcp_pkg;

  // Frame bytes
  localparam logic [7:0]  START_BYTE    = 8'h10;
  localparam logic [7:0]  PACKET_ID     = 8'h91;
  localparam logic [7:0]  MSG_SUBCODE   = 8'h01;
  localparam logic [7:0]  END_BYTE_1    = 8'h10;
  localparam logic [7:0]  END_BYTE_2    = 8'h03;
  localparam logic [7:0]  FIELD_SKIP    = 8'hFF;

  // Mode codes
  localparam logic [7:0]  MODE_QUERY    = 8'h00;
  localparam logic [7:0]  MODE_SET      = 8'h01;
  localparam logic [7:0]  MODE_RESP     = 8'h02;

  // Byte positions inside a frame
  localparam logic [15:0] POS_PKT_ID    = 16'h0001;
  localparam logic [15:0] POS_SUBCODE   = 16'h0002;
  localparam logic [15:0] POS_LEN_HI    = 16'h0003;
  localparam logic [15:0] POS_LEN_LO    = 16'h0004;
  localparam logic [15:0] POS_MODE      = 16'h0005;
  localparam logic [15:0] POS_MASK_LO   = 16'h0006;
  localparam logic [15:0] POS_MASK_HI   = 16'h0009;
  localparam logic [15:0] POS_ELEV_LO   = 16'h000A;
  localparam logic [15:0] POS_ELEV_HI   = 16'h000D;
  localparam logic [16:0] LEN_POS_BIAS  = 17'h0_0004;

  // Least length that carries each field
  localparam logic [15:0] LEN_WITH_MASK = 16'h0006;
  localparam logic [15:0] LEN_WITH_ELEV = 16'h000A;

  // Reply layout: mode + mask + elevation + checksum
  localparam logic [15:0] REPLY_LEN     = 16'h000A;
  localparam logic [4:0]  TX_POS_CSUM   = 5'h0E;
  localparam logic [4:0]  TX_POS_LAST   = 5'h10;

  // Band enable bits that the receiver acts on; highest elevation mask, 90.0 as a float
  localparam logic [31:0] BAND_SUPPORTED = 32'h00A3_5114;
  localparam logic [31:0] ELEV_MAX_90DEG = 32'h42B4_0000;

  // Register byte offsets
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_STATUS    = 5'h04;
  localparam logic [4:0]  REG_MASK      = 5'h08;
  localparam logic [4:0]  REG_BAND      = 5'h0C;
  localparam logic [4:0]  REG_ELEV      = 5'h10;

  // Control fields and reset value
  localparam int          CTRL_PARSE_EN = 0;
  localparam int          CTRL_REPLY_EN = 1;
  localparam int          CTRL_OD_MODE  = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h3;

  // Stored configuration
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] elev;
  } rcp_cfg_type;

endpackage : rcp_pkg

// File: rcp_host_model.sv
// Host model: sends framed configuration packets and collects replies
`timescale 1ns/1ps
`default_nettype none
module rcp_host_model
  import rcp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  output logic            tx_ready_out
);
  logic [7:0] reply_q[$];
  logic       stall;
  initial begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    stall        = 1'b0;
  end
  // Collect reply bytes; a stalling host toggles ready every cycle
  always @(posedge ref_clk_in) begin
    if (tx_valid_in && tx_ready_out) reply_q.push_back(tx_data_in);
    tx_ready_out <= stall ? !tx_ready_out : 1'b1;
  end
  // Length counts mode, data and checksum; checksum is left arbitrary
  task automatic send(input logic [7:0] m, input logic [15:0] l, input logic [63:0] d,
                      input logic [7:0] s, input logic [15:0] t);
    logic [7:0] fr[$];
    fr = {START_BYTE, PACKET_ID, s, l[15:8], l[7:0]};
    for (int j = 0; j < l; j++) begin
      if (j == 0) fr.push_back(m);
      else if (j < 9) fr.push_back(d[71-8*j -: 8]);
      else fr.push_back(8'h00);
    end
    fr.push_back(t[15:8]);
    fr.push_back(t[7:0]);
    foreach (fr[i]) begin
      @(posedge ref_clk_in);
      rx_data_out  <= fr[i];
      rx_valid_out <= 1'b1;
    end
    @(posedge ref_clk_in);
    rx_data_out  <= ~fr[fr.size()-1];
    rx_valid_out <= 1'b0;
  endtask : send
endmodule : rcp_host_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the configuration packet parser
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcp_pkg::*;
  logic        ref_clk_in;
  logic        reset_n_in;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [31:0] band;
  logic [31:0] elev;
  logic        apply;
  logic        ok;
  logic        err;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  int          n_mismatch;
  int          check_count;
  int          n_ok;
  int          n_err;

  rcp_parser i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .band_enable_out(band), .elev_min_out(elev),
    .elev_apply_out(apply), .frame_ok_out(ok), .frame_err_out(err), .avs_address_in(address),
    .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq));
  rcp_host_model i_host (.ref_clk_in(ref_clk_in), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = !ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (ok === 1'b1) n_ok++;
    if (err === 1'b1) n_err++;
  end

  function automatic logic [31:0] sup();
    int b[9] = '{2, 4, 8, 12, 14, 16, 17, 21, 23};
    sup = 32'h0000_0000;
    foreach (b[i]) sup[b[i]] = 1'b1;
  endfunction : sup
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic tick(inout int n);
    @(posedge ref_clk_in);
    n++;
    if (n > 300) begin
      n_mismatch++;
      $display("wrong value at %0t: wait timed out", $time);
      complete_run();
    end
  endtask : tick
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    address <= a;
    write   <= w;
    read    <= !w;
    wdata   <= d;
    do tick(n); while (waitreq !== 1'b0);
    q = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e, "register");
  endtask : rd
  task automatic frm(input logic [7:0] m, input logic [15:0] l, input logic [63:0] d,
                     input logic [7:0] s, input logic [15:0] t, input int eo, input int ee);
    int o;
    int e;
    o = n_ok;
    e = n_err;
    i_host.send(m, l, d, s, t);
    repeat (3) @(posedge ref_clk_in);
    chk(n_ok - o, eo, "good frames");
    chk(n_err - e, ee, "bad frames");
  endtask : frm

  task automatic t_reset();
    rd(REG_MASK, 32'h00A3_5114);
    rd(REG_BAND, sup());
    rd(5'h14, 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0000);
    chk(band, sup(), "band");
    chk({31'h0, apply}, 32'h0000_0000, "apply");
    $display("test reset done");
  endtask : t_reset
  task automatic t_set();
    frm(8'h01, 16'h000A, {32'hFFFF_FFF7, 32'h41F0_0000}, 8'h01, 16'h1003, 1, 0);
    rd(REG_MASK, 32'hFFFF_FFF7);
    rd(REG_BAND, 32'hFFFF_FFF7 & sup());
    chk(band, 32'hFFFF_FFF7 & sup(), "band");
    chk(elev, 32'h41F0_0000, "elev");
    $display("test set done");
  endtask : t_set
  task automatic t_query();
    logic [7:0] x[17];
    int n;
    n = 0;
    while (tx_valid !== 1'b0) tick(n);
    i_host.reply_q.delete();
    i_host.stall = 1'b1;
    frm(8'h00, 16'h0002, 64'h0, 8'h01, 16'h1003, 1, 0);
    x = '{8'h10, 8'h91, 8'h01, 8'h00, 8'h0A, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'hF7,
          8'h41, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h10, 8'h03};
    for (int i = 1; i < 14; i++) x[14] ^= x[i];
    while (i_host.reply_q.size() < 17) tick(n);
    foreach (x[i]) chk({24'h0, i_host.reply_q[i]}, {24'h0, x[i]}, "reply");
    i_host.stall = 1'b0;
    $display("test query done");
  endtask : t_query
  task automatic t_skip();
    logic [63:0] d[3] = '{{32'hFFFF_FFFF, 32'hFFFF_FFFF}, {32'h0000_0004, 32'h42B4_0001},
                          {32'h00A3_5114, 32'h0000_0000}};
    logic [15:0] l[3] = '{16'h000A, 16'h000A, 16'h0006};
    logic [31:0] m[3] = '{32'hFFFF_FFF7, 32'h0000_0004, 32'h00A3_5114};
    foreach (d[i]) begin
      frm(8'h01, l[i], d[i], 8'h01, 16'h1003, 1, 0);
      rd(REG_MASK, m[i]);
      rd(REG_ELEV, 32'h41F0_0000);
      chk(band, m[i] & sup(), "band");
    end
    $display("test skip done");
  endtask : t_skip
  task automatic t_bad();
    logic [7:0]  m[6] = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h01, 8'h01};
    logic [15:0] l[6] = '{16'h000A, 16'h000A, 16'h000A, 16'h0000, 16'h000A, 16'h000A};
    logic [7:0]  s[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
    logic [15:0] t[6] = '{16'h1004, 16'h1003, 16'h1003, 16'h1003, 16'h1203, 16'h1003};
    int          e[6] = '{1, 1, 1, 1, 1, 0};
    foreach (m[i]) begin
      frm(m[i], l[i], 64'h0000_0010_0000_0000, s[i], t[i], 0, e[i]);
      rd(REG_MASK, 32'h00A3_5114);
    end
    rd(REG_STATUS, 32'h0000_0505);
    $display("test bad done");
  endtask : t_bad
  task automatic t_ctrl();
    wr(REG_CTRL, 32'h0000_0007);
    rd(REG_CTRL, 32'h0000_0007);
    chk({31'h0, apply}, 32'h0000_0001, "apply");
    wr(REG_ELEV, 32'h42B4_0000);
    wr(REG_ELEV, 32'h42B4_0001);
    rd(REG_ELEV, 32'h42B4_0000);
    wr(REG_BAND, 32'h0000_0000);
    rd(REG_BAND, sup());
    wr(REG_CTRL, 32'h0000_0002);
    frm(8'h01, 16'h000A, 64'h0000_0010_42B4_0000, 8'h01, 16'h1003, 0, 0);
    wr(REG_CTRL, 32'h0000_0003);
    frm(8'h01, 16'h000A, 64'h0000_0010_42B4_0000, 8'h01, 16'h1003, 1, 0);
    rd(REG_MASK, 32'h0000_0010);
    chk({31'h0, apply}, 32'h0000_0000, "apply");
    $display("test control done");
  endtask : t_ctrl

  initial begin
    reset_n_in = 1'b0;
    address    = 5'h00;
    read       = 1'b0;
    write      = 1'b0;
    wdata      = 32'h0000_0000;
    repeat (6) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_set();
    t_query();
    t_skip();
    t_bad();
    t_ctrl();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
